/* src/darb_pkg.sv */
package darb_pkg;

   // ----------------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------------
   localparam logic [5:0] OFS_LIMIT_FAIL_FLAGS   = 6'h23; // limit-fail flags
   localparam logic [5:0] OFS_EXT_INPUT0_RESULT  = 6'h24; // input zero result
   localparam logic [5:0] OFS_EXT_INPUT1_RESULT  = 6'h25; // input one result
   localparam logic [5:0] OFS_DIE_TEMP_RESULT    = 6'h26; // temperature result
   localparam logic [5:0] OFS_SELF_DIAG_RESULT   = 6'h27; // self-diag mux result
   localparam logic [5:0] OFS_COMP_OFFSET        = 6'h28; // measured offset
   localparam logic [5:0] OFS_APPLIED_DAC_CODE   = 6'h2C; // applied dac code
   localparam logic [5:0] OFS_RAW_CONV_WORD      = 6'h2D; // raw conversion word
   localparam logic [5:0] OFS_OVERRIDE_CTRL      = 6'h2E; // override control
   localparam logic [5:0] OFS_THRESH_LO_BASE     = 6'h30; // low limits, 8 words
   localparam logic [5:0] OFS_THRESH_HI_BASE     = 6'h38; // high limits, 8 words

   // ----------------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------------
   localparam int         BIT_RESULT_OVR_EN   = 15; // result override enable
   localparam int         BIT_OFFSET_OVR_EN   = 14; // offset override enable
   localparam int         BIT_GND_SAMPLE_DIS  = 13; // ground sample disable
   localparam int         FLAG_LSB            = 1;  // lowest flag bit (input zero)
   localparam logic [15:0] RST_REG            = 16'h0000; // common reset value
   localparam logic [11:0] RST_HI_LIMIT       = 12'hFFF;  // high limit reset
   localparam logic [11:0] RST_LO_LIMIT       = 12'h000;  // low limit reset

   // ----------------------------------------------------------------------
   // diagnostic sources, in flag order from bit 1
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_INPUT_ZERO,
      SRC_INPUT_ONE,
      SRC_TEMPERATURE,
      SRC_REFERENCE,
      SRC_PAD_SUPPLY,
      SRC_CORE_SUPPLY,
      SRC_ZERO_TC_NODE,
      SRC_VOLTAGE_OUTPUT
   } darb_src_e;

   // one finished conversion from the analog core
   typedef struct packed {
      logic        valid; // conversion done strobe
      darb_src_e   src;   // source converted
      logic [11:0] raw;   // raw sar word
   } darb_conv_s;

   // override control fields
   typedef struct packed {
      logic        result_override_enable;
      logic        offset_override_enable;
      logic        ground_sample_disable;
      logic [11:0] data;
   } darb_ovr_s;

endpackage : darb_pkg

/* src/darb_top.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - one limit-fail flag per diagnostic source
// - input zero result, twelve bits, upper zero
// - input one result held twelve bits
// - temperature result held twelve bits
// - self-diag mux result held twelve bits
// - report measured offset, correct results with it
// - offset override uses bypass data field
// - report applied dac code, sixteen bits
// - raw word published uncorrected, unaffected by bypass
// - result override substitutes bypass data
// - substituted value stored and limit-checked
// - both enabled: offset wins, result override off
// - ground sampling on unless disable bit set
// - fault flag follows limit comparison
module darb_top #(
   parameter int DAC_W = 16 // dac code width
) (
   input  wire logic               sys_clk_i,        // 25 mhz clock
   input  wire logic               rst_i,            // sync reset, high
   input  wire logic [5:0]         reg_addr_i,       // register index
   input  wire logic [15:0]        reg_wdata_i,      // write data
   input  wire logic               reg_wr_i,         // write strobe
   input  wire logic               reg_rd_i,         // read strobe
   output logic [15:0]             reg_rdata_o,      // read data, next cycle
   input  wire darb_pkg::darb_conv_s conv_i,         // conversion from sar
   input  wire logic [11:0]        meas_offset_i,    // measured comparator offset
   input  wire logic               meas_offset_vld_i,// offset measurement done
   input  wire logic [DAC_W-1:0]   dac_applied_i,    // code driven to analog
   output logic                    gnd_sample_en_o   // sample ground between steps
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [15:0]      rdata;      // read data register
      logic [8:1]       flags;      // limit-fail flags
      logic [7:0][11:0] result;     // per-source results
      logic [11:0]      offset;     // measured offset
      logic [DAC_W-1:0] dac;        // applied dac code
      logic [11:0]      raw;        // last raw word
      darb_pkg::darb_ovr_s ovr;     // override control
      logic [7:0][11:0] lo_lim;     // low thresholds
      logic [7:0][11:0] hi_lim;     // high thresholds
      logic             gnd_en;     // ground sample enable
      logic [11:0]      sd_last;    // last self-diag mux result
   } darb_state_s;

   darb_state_s st;       // registered state
   darb_state_s next_st;  // next state

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // saturating signed correction of a raw word
   function automatic logic [11:0] darb_correct(input logic [11:0] raw,
                                                input logic [11:0] ofs);
      logic signed [13:0] sum;
      sum = $signed({2'b00, raw}) - $signed({{2{ofs[11]}}, ofs});
      if (sum < 0) begin
         return 12'h000;
      end else if (sum > 14'sd4095) begin
         return 12'hFFF;
      end else begin
         return sum[11:0];
      end
   endfunction : darb_correct

   // pad a 12-bit value into a 16-bit read word
   function automatic logic [15:0] darb_pad12(input logic [11:0] v);
      return {4'h0, v};
   endfunction : darb_pad12

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   logic        ofs_win;   // offset override in force
   logic        res_win;   // result override in force
   logic [11:0] use_ofs;   // offset applied to correction
   logic [11:0] value;     // value stored for this conversion
   logic [2:0]  idx;       // source index
   logic [2:0]  aidx;      // threshold index from address

   always_comb begin
      next_st  = st;
      idx      = conv_i.src;
      aidx     = reg_addr_i[2:0];
      ofs_win  = st.ovr.offset_override_enable;
      res_win  = st.ovr.result_override_enable & ~st.ovr.offset_override_enable;
      use_ofs  = ofs_win ? st.ovr.data : st.offset;
      value    = res_win ? st.ovr.data : darb_correct(conv_i.raw, use_ofs);

      if (meas_offset_vld_i) begin
         next_st.offset = meas_offset_i;
      end
      next_st.dac = dac_applied_i;

      if (conv_i.valid) begin
         next_st.raw = conv_i.raw;
         next_st.result[idx] = value;
         // sources 3..7 share the self-diag mux result
         if (idx >= 3'h3) begin
            next_st.sd_last = value;
         end
         next_st.flags[4'(idx) + 4'(darb_pkg::FLAG_LSB)] =
            (value < st.lo_lim[idx]) | (value > st.hi_lim[idx]);
      end

      next_st.gnd_en = ~st.ovr.ground_sample_disable;

      // register writes; read-only targets ignored
      if (reg_wr_i) begin
         if (reg_addr_i == darb_pkg::OFS_OVERRIDE_CTRL) begin
            next_st.ovr.result_override_enable =
               reg_wdata_i[darb_pkg::BIT_RESULT_OVR_EN];
            next_st.ovr.offset_override_enable =
               reg_wdata_i[darb_pkg::BIT_OFFSET_OVR_EN];
            next_st.ovr.ground_sample_disable =
               reg_wdata_i[darb_pkg::BIT_GND_SAMPLE_DIS];
            next_st.ovr.data = reg_wdata_i[11:0];
         end else if (reg_addr_i[5:3] == darb_pkg::OFS_THRESH_LO_BASE[5:3]) begin
            next_st.lo_lim[aidx] = reg_wdata_i[11:0];
         end else if (reg_addr_i[5:3] == darb_pkg::OFS_THRESH_HI_BASE[5:3]) begin
            next_st.hi_lim[aidx] = reg_wdata_i[11:0];
         end
      end

      // read mux, one cycle later
      next_st.rdata = darb_pkg::RST_REG;
      if (reg_rd_i) begin
         case (reg_addr_i)
            darb_pkg::OFS_LIMIT_FAIL_FLAGS:  next_st.rdata = {7'h00, st.flags, 1'b0};
            darb_pkg::OFS_EXT_INPUT0_RESULT: next_st.rdata = darb_pad12(st.result[0]);
            darb_pkg::OFS_EXT_INPUT1_RESULT: next_st.rdata = darb_pad12(st.result[1]);
            darb_pkg::OFS_DIE_TEMP_RESULT:   next_st.rdata = darb_pad12(st.result[2]);
            darb_pkg::OFS_SELF_DIAG_RESULT:  next_st.rdata = darb_pad12(st.sd_last);
            darb_pkg::OFS_COMP_OFFSET:       next_st.rdata = darb_pad12(st.offset);
            darb_pkg::OFS_APPLIED_DAC_CODE:  next_st.rdata = 16'(st.dac);
            darb_pkg::OFS_RAW_CONV_WORD:     next_st.rdata = darb_pad12(st.raw);
            darb_pkg::OFS_OVERRIDE_CTRL: begin
               // readback shows result override forced low under priority
               next_st.rdata = {res_win, st.ovr.offset_override_enable,
                                st.ovr.ground_sample_disable, 1'b0, st.ovr.data};
            end
            default: begin
               if (reg_addr_i[5:3] == darb_pkg::OFS_THRESH_LO_BASE[5:3]) begin
                  next_st.rdata = darb_pad12(st.lo_lim[aidx]);
               end else if (reg_addr_i[5:3] == darb_pkg::OFS_THRESH_HI_BASE[5:3]) begin
                  next_st.rdata = darb_pad12(st.hi_lim[aidx]);
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st        <= '0;
         st.hi_lim <= {8{darb_pkg::RST_HI_LIMIT}};
         st.lo_lim <= {8{darb_pkg::RST_LO_LIMIT}};
         st.gnd_en <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_o     = st.rdata;
   assign gnd_sample_en_o = st.gnd_en;

endmodule : darb_top

/* dv/darb_host.sv */
`timescale 1ns/10ps
// host master model: one-cycle strobes, lines inverted when idle
module darb_host (
   input  wire logic        clk_i,   // bus clock
   output logic [5:0]       addr_o,  // register index
   output logic [15:0]      wdata_o, // write data
   output logic             wr_o,    // write strobe
   output logic             rd_o,    // read strobe
   input  wire logic [15:0] rdata_i  // read data
);
   initial begin
      {addr_o, wdata_o, wr_o, rd_o} = '0;
   end
   // write: strobe for one edge, then release
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
   endtask : wr
   // read: data taken in the cycle after the strobe
   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk_i);
      {addr_o, rd_o} <= {a, 1'b1};
      @(posedge clk_i);
      {addr_o, rd_o} <= {~a, 1'b0};
      #1 d = rdata_i;
   endtask : rd
endmodule : darb_host

/* dv/darb_top_asserts.sv */
`timescale 1ns/10ps
// port checker for the result and override registers
module darb_chk #(parameter int DAC_W = 16) (
   input wire logic             sys_clk_i,      // clock
   input wire logic             rst_i,          // sync reset
   input wire logic [5:0]       reg_addr_i,     // register index
   input wire logic [15:0]      reg_wdata_i,    // write data
   input wire logic             reg_wr_i,       // write strobe
   input wire logic             reg_rd_i,       // read strobe
   input wire logic [15:0]      reg_rdata_o,    // read data
   input wire logic [DAC_W-1:0] dac_applied_i,  // applied code
   input wire logic             gnd_sample_en_o // ground sampling
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   idle_rdata_zero_a: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data not idle");
   unmapped_zero_a: assert property (
      reg_rd_i && reg_addr_i == 6'h00 |=> reg_rdata_o == 16'h0000) else $error("unmapped read");
   result_upper_a: assert property (
      reg_rd_i && reg_addr_i inside {[6'h24:6'h28], 6'h2D} |=> reg_rdata_o[15:12] == 4'h0)
      else $error("result upper bits set");
   flag_reserved_a: assert property (
      reg_rd_i && reg_addr_i == 6'h23 |=> reg_rdata_o[15:9] == 7'h00 && !reg_rdata_o[0])
      else $error("flag reserved bits set");
   gnd_follow_a: assert property (
      reg_wr_i && reg_addr_i == 6'h2E ##1 !(reg_wr_i && reg_addr_i == 6'h2E)
      |=> gnd_sample_en_o == !$past(reg_wdata_i[13], 2)) else $error("ground sampling wrong");
   gnd_reset_a: assert property (
      $past(rst_i) |-> gnd_sample_en_o) else $error("ground sampling off after reset");
   dac_readback_a: assert property (
      reg_rd_i && reg_addr_i == 6'h2C && $stable(dac_applied_i)
      |=> reg_rdata_o == $past(dac_applied_i)) else $error("dac readback wrong");
   ovr_priority_a: assert property (
      reg_rd_i && reg_addr_i == 6'h2E |=> !(reg_rdata_o[15] && reg_rdata_o[14]) && !reg_rdata_o[12])
      else $error("override control readback wrong");
endmodule : darb_chk
bind darb_top darb_chk #(.DAC_W(DAC_W)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .dac_applied_i(dac_applied_i),
   .gnd_sample_en_o(gnd_sample_en_o));

/* dv/tb.sv */
`timescale 1ns/10ps
module tb;
   logic                 sys_clk_i = 1'b0; // 25 mhz clock
   logic                 rst_i = 1'b1;     // sync reset
   darb_pkg::darb_conv_s conv = '0;        // conversion input
   logic [11:0]          mofs = 12'h000;   // measured offset
   logic                 mvld = 1'b0;      // offset strobe
   logic [15:0]          dac = 16'h0000;   // applied dac code
   logic [15:0]          rdata;            // read data
   logic [5:0]           addr;             // register index
   logic [15:0]          wdata;            // write data
   logic                 wr;               // write strobe
   logic                 rd;               // read strobe
   logic                 gnd;              // ground sampling
   int                   n_mismatch = 0;   // mismatches
   int                   compares = 0;     // comparisons
   always #20 sys_clk_i = ~sys_clk_i;
   darb_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .conv_i(conv), .meas_offset_i(mofs),
      .meas_offset_vld_i(mvld), .dac_applied_i(dac), .gnd_sample_en_o(gnd));
   darb_host host (.clk_i(sys_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdata));
   task automatic conclude();
      if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // read a register and compare
   task automatic rdc(input logic [5:0] a, input logic [15:0] e);
      logic [15:0] d;
      host.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask : rdc
   // one finished conversion pulse
   task automatic cv(input logic [2:0] s, input logic [11:0] r);
      @(posedge sys_clk_i);
      conv <= '{1'b1, darb_pkg::darb_src_e'(s), r};
      @(posedge sys_clk_i);
      conv.valid <= 1'b0;
   endtask : cv
   task automatic t_reset();
      logic [5:0] regs[9] = '{6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h2C, 6'h2D, 6'h2E};
      foreach (regs[i]) rdc(regs[i], 16'h0000);
      rdc(6'h00, 16'h0000);
      chk("gnd", 16'h0001, {15'h0000, gnd});
   endtask : t_reset
   // every source, odd ones above the high limit
   task automatic t_conv();
      @(posedge sys_clk_i);
      {mofs, mvld} <= {12'h010, 1'b1};
      @(posedge sys_clk_i);
      mvld <= 1'b0;
      for (int s = 0; s < 8; s++) begin
         host.wr(6'h38 + 6'(s), 16'h07FF);
         cv(3'(s), s[0] ? 12'h900 : 12'h400);
         rdc(s < 3 ? 6'h24 + 6'(s) : 6'h27, s[0] ? 16'h08F0 : 16'h03F0);
         rdc(6'h2D, s[0] ? 16'h0900 : 16'h0400);
      end
      rdc(6'h28, 16'h0010);
      rdc(6'h23, 16'h0154);
   endtask : t_conv
   task automatic t_ovr();
      host.wr(6'h2E, 16'h8123);
      cv(3'd1, 12'h777);
      rdc(6'h25, 16'h0123);
      rdc(6'h2D, 16'h0777);
      rdc(6'h23, 16'h0150);
      host.wr(6'h2E, 16'h4FFE);
      cv(3'd0, 12'h300);
      rdc(6'h24, 16'h0302);
      rdc(6'h28, 16'h0010);
      host.wr(6'h2E, 16'hC005); // both set on purpose
      rdc(6'h2E, 16'h4005);
      cv(3'd2, 12'h100);
      rdc(6'h26, 16'h00FB);
      host.wr(6'h2E, 16'h3FFF);
      rdc(6'h2E, 16'h2FFF);
      chk("gnd", 16'h0000, {15'h0000, gnd});
      host.wr(6'h24, 16'hFFFF);
      rdc(6'h24, 16'h0302);
   endtask : t_ovr
   task automatic t_dac();
      @(posedge sys_clk_i);
      dac <= 16'hA5C3;
      rdc(6'h2C, 16'hA5C3);
   endtask : t_dac
   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_conv();
      t_ovr();
      t_dac();
      conclude();
   end
   // watchdog, far beyond the expected run
   initial begin
      #(40 * 5000);
      n_mismatch++;
      conclude();
   end
endmodule : tb
